//--- design/config_prom_regs.svh
// constants for the configuration memory address sequencer
`ifndef CONFIG_PROM_REGS_SVH
`define CONFIG_PROM_REGS_SVH
// release delay after power-on threshold, in microseconds
`define OER_MIN_US 500
`define OER_SERIAL_MAX_US 3000
`define OER_PARALLEL_MAX_US 30000
`define CLK_MHZ 100
// cycles: least time rounded up (us * MHz is exact at 100 MHz)
`define OER_CYCLES (`OER_MIN_US * `CLK_MHZ)
`define ADDR_RESET_VALUE 0
`endif

//--- design/config_prom_pkg.sv
// types for the configuration memory address sequencer
package config_prom_pkg;
  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_HELD,
    ST_RUN,
    ST_STOPPED
  } seq_state_t;
endpackage : config_prom_pkg

//--- design/config_prom_fifo.sv
// small synchronous fifo carrying memory words toward the data pins
module config_prom_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // refused at elaboration: pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [WIDTH-1:0] next_out_data;
  logic next_out_valid, do_wr, do_rd;
  // *****************************
  // pointer and read register update
  // *****************************
  always_comb
  begin
    in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
    do_wr = in_valid && in_ready;
    do_rd = (wr_ptr != rd_ptr) && (!out_valid || out_ready);
    next_wr_ptr = wr_ptr + (AW + 1)'(do_wr);
    next_rd_ptr = rd_ptr + (AW + 1)'(do_rd);
    next_out_data = do_rd ? mem[rd_ptr[AW-1:0]] : out_data;
    next_out_valid = do_rd ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    if (flush)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_out_valid = 1'b0;
    end
  end
  // read data leaves from a register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end
  // storage has no reset
  always_ff @(posedge sys_clk)
  begin
    if (do_wr) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : config_prom_fifo

//--- design/config_prom_address_sequencer.sv
// address sequencer and pin control of a configuration memory
`include "config_prom_regs.svh"
module config_prom_address_sequencer #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8,
  parameter int FIFO_DEPTH = 32,
  parameter int OER_CYCLES = `OER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic device_select_n,
  input wire logic oe_reset_in,
  output logic oe_reset_out,
  output logic oe_reset_oe,
  input wire logic config_clk,
  input wire logic config_restart_n,
  input wire logic flow_hold,
  input wire logic revision_enable,
  input wire logic parallel_mode,
  input wire logic decompress_enable,
  input wire logic [ADDR_W-1:0] revision_start_address,
  input wire logic [ADDR_W-1:0] revision_end_address,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_req,
  input wire logic mem_ready,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic mem_rvalid,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic clock_output,
  output logic clock_output_oe,
  output logic cascade_enable_out_n,
  output logic standby,
  output logic [ADDR_W-1:0] address
);
  localparam logic [ADDR_W-1:0] TERMINAL_COUNT = '1;
  // refused at elaboration: the counter and release delay need these minimums
  if (ADDR_W < 2 || DATA_W < 1 || OER_CYCLES < 1)
  begin : g_bad_params
    $error("unsupported parameter values");
  end
  // last address of the stream: top of memory or end of the selected revision
  function automatic logic is_last(input logic [ADDR_W-1:0] a, input logic rev_en, input logic [ADDR_W-1:0] rev_end);
    return a == TERMINAL_COUNT || (rev_en && a == rev_end);
  endfunction : is_last
  // *****************************
  // pin synchronisers
  // *****************************
  logic [4:0] sync1, sync2;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= 5'h1a;
      sync2 <= 5'h1a;
    end
    else
    begin
      sync1 <= {device_select_n, oe_reset_in, config_clk, config_restart_n, flow_hold};
      sync2 <= sync1;
    end
  end
  logic sel_n, oe_in, cclk, restart_n, hold_pin, cclk_d;
  assign {sel_n, oe_in, cclk, restart_n, hold_pin} = sync2;
  // *****************************
  // power-up release and sequencer
  // *****************************
  config_prom_pkg::seq_state_t state, next_state;
  logic [31:0] por_count, next_por_count;
  logic [ADDR_W-1:0] next_address, start_addr;
  logic hold_ok, rise, at_tc, at_ea, in_reset, advance;
  logic next_oe_out, next_oe_oe, next_cascade, next_standby, next_clk_oe, next_data_oe, next_cclk_d;
  logic [DATA_W-1:0] next_data_out;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
  logic [DATA_W-1:0] fifo_out_data;
  always_comb
  begin
    hold_ok = parallel_mode && !decompress_enable && hold_pin;
    rise = cclk && !cclk_d;
    start_addr = revision_enable ? revision_start_address : ADDR_W'(`ADDR_RESET_VALUE);
    at_tc = address == TERMINAL_COUNT;
    at_ea = revision_enable && address == revision_end_address;
    in_reset = sel_n || !oe_in || state == config_prom_pkg::ST_POWERUP;
    next_state = state;
    next_por_count = por_count;
    next_address = address;
    next_cclk_d = cclk;
    advance = 1'b0;
    fifo_flush = 1'b0;
    fifo_out_ready = 1'b0;
    next_oe_oe = 1'b0;
    next_data_out = data_out;
    case (state)
      config_prom_pkg::ST_POWERUP:
      begin
        next_oe_oe = 1'b1;
        next_por_count = por_count + 32'h1;
        if (por_count >= 32'(OER_CYCLES - 1)) next_state = config_prom_pkg::ST_HELD;
        next_address = start_addr;
        fifo_flush = 1'b1;
      end
      config_prom_pkg::ST_HELD:
      begin
        next_address = start_addr;
        fifo_flush = 1'b1;
        if (!in_reset) next_state = config_prom_pkg::ST_RUN;
      end
      config_prom_pkg::ST_RUN, config_prom_pkg::ST_STOPPED:
      begin
        if (in_reset)
        begin
          next_state = config_prom_pkg::ST_HELD;
          next_address = start_addr;
          fifo_flush = 1'b1;
        end
        else if (!restart_n)
        begin
          next_address = start_addr;
          fifo_flush = 1'b1;
          next_state = config_prom_pkg::ST_RUN;
        end
        else if (at_tc || at_ea)
        begin
          next_state = config_prom_pkg::ST_STOPPED;
        end
        else if (rise && !hold_ok && state == config_prom_pkg::ST_RUN && fifo_out_valid)
        begin
          fifo_out_ready = 1'b1;
          next_data_out = fifo_out_data;
          advance = 1'b1;
          next_address = address + ADDR_W'(1);
          // stop on the edge that lands on the end, so pins float at once
          if (is_last(next_address, revision_enable, revision_end_address))
            next_state = config_prom_pkg::ST_STOPPED;
        end
      end
      default: next_state = config_prom_pkg::ST_HELD;
    endcase
    next_oe_out = 1'b0;
    next_standby = sel_n;
    next_cascade = !(next_state == config_prom_pkg::ST_STOPPED && next_address == TERMINAL_COUNT);
    next_data_oe = next_state == config_prom_pkg::ST_RUN && !in_reset;
    next_clk_oe = next_data_oe;
  end
  // word fetch feeds the fifo ahead of the stream
  logic [ADDR_W-1:0] fetch_addr, next_fetch_addr;
  logic fetch_busy, next_fetch_busy, fetch_done, next_fetch_done, next_mem_req;
  always_comb
  begin
    next_fetch_addr = fetch_addr;
    next_fetch_busy = fetch_busy;
    next_fetch_done = fetch_done;
    next_mem_req = 1'b0;
    if (fifo_flush || (!restart_n && !in_reset))
    begin
      next_fetch_addr = start_addr;
      next_fetch_busy = 1'b0;
      next_fetch_done = 1'b0;
    end
    else if (fetch_busy)
    begin
      if (mem_rvalid)
      begin
        next_fetch_busy = 1'b0;
        if (is_last(fetch_addr, revision_enable, revision_end_address))
          next_fetch_done = 1'b1;
        else
          next_fetch_addr = fetch_addr + ADDR_W'(1);
      end
    end
    else if (!fetch_done && fifo_in_ready && mem_ready && !mem_req)
    begin
      next_mem_req = 1'b1;
      next_fetch_busy = 1'b1;
    end
  end
  // state, fetch and pin output registers here
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= config_prom_pkg::ST_POWERUP;
      por_count <= 32'h0;
      address <= '0;
      cclk_d <= 1'b0;
      oe_reset_out <= 1'b0;
      oe_reset_oe <= 1'b1;
      cascade_enable_out_n <= 1'b1;
      standby <= 1'b1;
      data_oe <= 1'b0;
      clock_output_oe <= 1'b0;
      clock_output <= 1'b0;
      data_out <= '0;
      fetch_addr <= '0;
      fetch_busy <= 1'b0;
      fetch_done <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= '0;
    end
    else
    begin
      state <= next_state;
      por_count <= next_por_count;
      address <= next_address;
      cclk_d <= next_cclk_d;
      oe_reset_out <= next_oe_out;
      oe_reset_oe <= next_oe_oe;
      cascade_enable_out_n <= next_cascade;
      standby <= next_standby;
      data_oe <= next_data_oe;
      clock_output_oe <= next_clk_oe;
      clock_output <= cclk;
      data_out <= next_data_out;
      fetch_addr <= next_fetch_addr;
      fetch_busy <= next_fetch_busy;
      fetch_done <= next_fetch_done;
      mem_req <= next_mem_req;
      mem_addr <= next_fetch_addr;
    end
  end
  // stream buffer; the sequencer stalls while it is empty
  config_prom_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(fifo_flush || (!restart_n && !in_reset)),
    .in_valid(mem_rvalid && fetch_busy),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  // *****************************
  // assertions
  // *****************************
  property p_standby;
    @(posedge sys_clk) disable iff (rst) sel_n |=> standby && cascade_enable_out_n && !data_oe;
  endproperty
  a_standby: assert property (p_standby) else $error("select high not standby");
  property p_advance;
    @(posedge sys_clk) disable iff (rst) advance && !at_tc && !at_ea |=> address == $past(address) + ADDR_W'(1);
  endproperty
  a_advance: assert property (p_advance) else $error("address did not advance");
  property p_tc;
    @(posedge sys_clk) disable iff (rst) state == config_prom_pkg::ST_STOPPED && at_tc |-> !cascade_enable_out_n;
  endproperty
  a_tc: assert property (p_tc) else $error("cascade not low at terminal count");
  property p_end_float;
    @(posedge sys_clk) disable iff (rst) state == config_prom_pkg::ST_STOPPED
      |-> !data_oe && !clock_output_oe && (at_tc || cascade_enable_out_n);
  endproperty
  a_end_float: assert property (p_end_float) else $error("pins driven or cascade low after stop");
  property p_tc_hold;
    @(posedge sys_clk) disable iff (rst) state == config_prom_pkg::ST_STOPPED && !in_reset && restart_n |=> $stable(address);
  endproperty
  a_tc_hold: assert property (p_tc_hold) else $error("address moved after stop");
  property p_hold;
    @(posedge sys_clk) disable iff (rst) hold_ok && !in_reset && restart_n |=> $stable(address);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved during hold");
  property p_reset_addr;
    @(posedge sys_clk) disable iff (rst) in_reset |=> address == $past(start_addr);
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("address not reset");
  property p_release;
    @(posedge sys_clk) disable iff (rst) state == config_prom_pkg::ST_POWERUP |=> oe_reset_oe && !oe_reset_out;
  endproperty
  a_release: assert property (p_release) else $error("line released early");
  property p_por_len;
    @(posedge sys_clk) disable iff (rst) state == config_prom_pkg::ST_POWERUP && next_state != state |-> por_count == 32'(OER_CYCLES - 1);
  endproperty
  a_por_len: assert property (p_por_len) else $error("release delay wrong");
  property p_float;
    @(posedge sys_clk) disable iff (rst) !oe_in |=> !data_oe && !clock_output_oe;
  endproperty
  a_float: assert property (p_float) else $error("outputs driven in reset");
endmodule : config_prom_address_sequencer

//--- tb/config_target_model.sv
// behavioural model of the target fpga configuration logic driving the memory's control pins
module config_target_model (
  input wire logic sys_clk,
  output logic config_clk,
  output logic config_restart_n,
  output logic device_select_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // pin drive
  // ****************************************
  // clock idles low between edges; device select is driven low, so the memory is selected and standby goes low once out of reset
  initial
  begin
    config_clk = 1'b0;
    config_restart_n = 1'b1;
    device_select_n = 1'b0;
  end

  // one configuration clock: high three cycles, low four, so synced edge and data both land
  task automatic cclk_edge();
    @(negedge sys_clk) config_clk = 1'b1;
    repeat (3) @(negedge sys_clk);
    config_clk = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask : cclk_edge

  // address restart pulse, then idle so the fifo can refill before the next edge
  task automatic restart();
    @(negedge sys_clk) config_restart_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    config_restart_n = 1'b1;
    repeat (12) @(negedge sys_clk);
  endtask : restart

  task automatic select(input logic level_n);
    @(negedge sys_clk) device_select_n = level_n;
    repeat (12) @(negedge sys_clk);
  endtask : select
endmodule : config_target_model

//--- tb/testbench.sv
// self-checking bench for the configuration memory address sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals and instances
  // ****************************************
  logic sys_clk = 1'b0, rst = 1'b1, pull_low = 1'b0, flow_hold = 1'b0;
  logic revision_enable = 1'b0, parallel_mode = 1'b0, decompress_enable = 1'b0;
  logic config_clk, config_restart_n, device_select_n, oe_reset_out, oe_reset_oe, oe_reset_in;
  logic mem_req, mem_rvalid = 1'b0, data_oe, clock_output, clock_output_oe, cascade_enable_out_n, standby;
  logic [3:0] mem_addr, address;
  logic [7:0] mem_rdata = 8'h00, data_out;
  logic mem_ready = 1'b1;
  logic [3:0] rev_start = 4'h4, rev_end = 4'h6;
  int n_errors = 0, n_tests = 0;

  always #5 sys_clk = ~sys_clk;
  // line has a pull-up; the device or the bench may pull it low
  assign oe_reset_in = (oe_reset_oe ? oe_reset_out : 1'b1) & ~pull_low;

  // small address space so terminal count is reachable; short release delay for sim time
  config_prom_address_sequencer #(.ADDR_W(4), .DATA_W(8), .FIFO_DEPTH(32), .OER_CYCLES(20)) uut (
    .sys_clk(sys_clk), .rst(rst), .device_select_n(device_select_n), .oe_reset_in(oe_reset_in),
    .oe_reset_out(oe_reset_out), .oe_reset_oe(oe_reset_oe), .config_clk(config_clk),
    .config_restart_n(config_restart_n), .flow_hold(flow_hold), .revision_enable(revision_enable),
    .parallel_mode(parallel_mode), .decompress_enable(decompress_enable),
    .revision_start_address(rev_start), .revision_end_address(rev_end), .mem_addr(mem_addr), .mem_req(mem_req),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .data_out(data_out), .data_oe(data_oe),
    .clock_output(clock_output), .clock_output_oe(clock_output_oe),
    .cascade_enable_out_n(cascade_enable_out_n), .standby(standby), .address(address));

  config_target_model fpga (.sys_clk(sys_clk), .config_clk(config_clk),
    .config_restart_n(config_restart_n), .device_select_n(device_select_n));

  // ****************************************
  // storage model and helpers
  // ****************************************
  // stored word tells its own address apart from neighbours
  function automatic logic [7:0] word(input logic [3:0] a);
    return {a, ~a};
  endfunction : word

  // one-cycle answer to each storage request
  always @(posedge sys_clk)
  begin
    mem_rvalid <= mem_req;
    mem_rdata <= word(mem_addr);
    // storage busy every other cycle, so fetches must wait for ready
    mem_ready <= ~mem_ready;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one clock edge, then address, drive and cascade compared
  task automatic step(input logic [3:0] a, input logic oe, input logic ceo_n);
    fork
      fpga.cclk_edge();
      begin
        repeat (4) @(negedge sys_clk);
        chk("clock_output", 8'h01, {7'h0, clock_output});
      end
    join
    chk("clock_output_oe", {7'h0, oe}, {7'h0, clock_output_oe});
    chk("address", {4'h0, a}, {4'h0, address});
    chk("data_oe", {7'h0, oe}, {7'h0, data_oe});
    chk("cascade", {7'h0, ceo_n}, {7'h0, cascade_enable_out_n});
    if (oe)
      chk("data_out", word(a - 4'h1), data_out);
  endtask : step

  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (20) @(negedge sys_clk);
    chk("oe_reset_oe", 8'h01, {7'h0, oe_reset_oe});
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk("oe_reset_oe", 8'h01, {7'h0, oe_reset_oe});
    chk("oe_reset_in", 8'h00, {7'h0, oe_reset_in});
    repeat (30) @(negedge sys_clk);
    chk("oe_reset_oe", 8'h00, {7'h0, oe_reset_oe});
    repeat (10) @(negedge sys_clk);
    // count up from zero to terminal count
    for (int i = 1; i < 15; i++)
      step(i[3:0], 1'b1, 1'b1);
    step(4'hf, 1'b0, 1'b0);
    step(4'hf, 1'b0, 1'b0);
    // standby resets the counter whatever the line level
    fpga.select(1'b1);
    chk("standby", 8'h01, {7'h0, standby});
    chk("address", 8'h00, {4'h0, address});
    chk("cascade", 8'h01, {7'h0, cascade_enable_out_n});
    chk("float", 8'h00, {6'h0, data_oe, clock_output_oe});
    fpga.select(1'b0);
    // hold honoured only for parallel output without decompression
    parallel_mode = 1'b1;
    step(4'h1, 1'b1, 1'b1);
    flow_hold = 1'b1;
    step(4'h1, 1'b1, 1'b1);
    step(4'h1, 1'b1, 1'b1);
    decompress_enable = 1'b1;
    step(4'h2, 1'b1, 1'b1);
    flow_hold = 1'b0;
    decompress_enable = 1'b0;
    // line pulled low from outside resets the counter
    pull_low = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("address", 8'h00, {4'h0, address});
    chk("data_oe", 8'h00, {7'h0, data_oe});
    chk("cascade", 8'h01, {7'h0, cascade_enable_out_n});
    pull_low = 1'b0;
    // revision bank: restart to its start, stop at its end with cascade high
    revision_enable = 1'b1;
    fpga.restart();
    chk("address", 8'h04, {4'h0, address});
    step(4'h5, 1'b1, 1'b1);
    step(4'h6, 1'b0, 1'b1);
    step(4'h6, 1'b0, 1'b1);
    chk("clock_output_oe", 8'h00, {7'h0, clock_output_oe});
    // revision ending on the top address also hands over downstream
    rev_start = 4'hd;
    rev_end = 4'hf;
    fpga.restart();
    chk("address", 8'h0d, {4'h0, address});
    step(4'he, 1'b1, 1'b1);
    step(4'hf, 1'b0, 1'b0);
    print_verdict();
  end

  // watchdog so a stuck run still reaches the verdict
  initial
  begin
    #200us;
    n_errors++;
    print_verdict();
  end
endmodule : testbench
